// ### hdl/slbc_consts.svh
`ifndef SLBC_CONSTS_SVH
`define SLBC_CONSTS_SVH
// register byte addresses (word index times four)
`define SLBC_IDX_FWD_ERR      8'h25
`define SLBC_ADDR_FWD_ERR     8'h94
`define SLBC_ADDR_CTRL        8'h00
`define SLBC_ADDR_STATUS      8'h04
`define SLBC_ADDR_IRQ_STAT    8'h08
`define SLBC_ADDR_IRQ_MASK    8'h0c
// control fields
`define SLBC_CTRL_EN_BIT      0
`define SLBC_CTRL_OSC_BIT     1
// status fields
`define SLBC_ST_ACTIVE_BIT    0
`define SLBC_ST_CHECK_BIT     1
`define SLBC_ST_LOCK_BIT      2
`define SLBC_ST_RESULT_BIT    3
`define SLBC_ST_CLKSEL_BIT    4
// interrupt fields
`define SLBC_IRQ_ERR_BIT      0
`define SLBC_IRQ_DONE_BIT     1
`define SLBC_IRQ_START_BIT    2
`define SLBC_IRQ_W            3
// reset values
`define SLBC_CTRL_RST         2'h0
`define SLBC_MASK_RST         3'h0
`define SLBC_ERR_RST          8'h00
// symbol geometry and timing
`define SLBC_SYM_W            35
`define SLBC_OSC_MHZ          33
`define SLBC_CLK_MHZ          250
`endif

// ### hdl/slbc_pkg.sv
package slbc_pkg;
   // gray coded along idle -> request -> check -> done
   typedef enum logic [1:0] {
      SLBC_IDLE  = 2'b00,
      SLBC_REQ   = 2'b01,
      SLBC_CHECK = 2'b11,
      SLBC_DONE  = 2'b10
   } slbc_state_t;
endpackage

// ### hdl/slbc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module slbc_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // pins
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] level_o
);
   logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
   logic [W-1:0] s1_d, s2_d, s3_d, lvl_d;

   always_comb begin
      s1_d  = async_i;
      s2_d  = s1_q;
      s3_d  = s2_q;
      // a change counts only when stages two and three agree
      lvl_d = lvl_q;
      for (int i = 0; i < W; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            lvl_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         lvl_q <= '0;
      end else begin
         s1_q  <= s1_d;
         s2_q  <= s2_d;
         s3_q  <= s3_d;
         lvl_q <= lvl_d;
      end
   end

   assign level_o = lvl_q;
endmodule // slbc_sync
`default_nettype wire

// ### hdl/slbc_checker.sv
// Function
// - self-test starts when the enable pin or the control register bit is set
// - test clock is pixel clock or internal oscillator, the oscillator chosen by pin or register only when pixel clock is absent
// - on activation, raise the back-channel test request to the serializer
// - with both ends in test and lock, result goes high and checking starts
// - each errored symbol pulses result low for half a pixel clock
// - enable low ends test; checking stops and final result is latched
// - after the test, result high if no error, steady low otherwise
// - final result kept until new test or reset
// - lock indication stays valid throughout the test
// - link returns to normal operation once the enable pin and the control register enable bit are both low
// - forward errors found while locked are counted in a readable register
`timescale 1ns/1ns
`default_nettype none
`include "slbc_consts.svh"
module slbc_checker
   import slbc_pkg::*;
#(
   parameter int SYM_W = `SLBC_SYM_W
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // wishbone slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [7:0]       wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   // test pins
   input  wire logic             self_test_enable_pin_i,
   input  wire logic             self_test_clock_select_pin_i,
   input  wire logic             pclk_present_i,
   output logic                  result_pin_o,
   output logic                  use_internal_oscillator_o,
   // receive data path
   input  wire logic             rx_lock_i,
   input  wire logic             remote_in_test_i,
   input  wire logic             sym_valid_i,
   input  wire logic [SYM_W-1:0] sym_payload_i,
   input  wire logic             half_pclk_en_i,
   // back channel and status
   output logic                  bc_test_request_o,
   output logic                  lock_o,
   output logic                  normal_mode_o,
   output logic                  irq_o
);
   logic [1:0] pins_s;
   logic       en_pin, clk_pin;

   slbc_sync #(.W(2)) u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i ({self_test_clock_select_pin_i, self_test_enable_pin_i}),
      .level_o (pins_s)
   );
   assign en_pin  = pins_s[0];
   assign clk_pin = pins_s[1];

   function automatic logic is_error(input logic [SYM_W-1:0] p);
      return |p;
   endfunction

   // registers
   slbc_state_t               st_q, st_d;
   logic [1:0]                ctrl_q, ctrl_d;
   logic [`SLBC_IRQ_W-1:0]    ist_q, ist_d, imask_q, imask_d;
   logic [7:0]                err_q, err_d;
   logic                      res_q, res_d, any_err_q, any_err_d;
   logic                      pulse_q, pulse_d, ack_q, ack_d;
   logic [31:0]               rdat_q, rdat_d;
   logic                      req_q, req_d, osc_q, osc_d, lock_q, lock_d;
   logic                      norm_q, norm_d, irq_q, irq_d;
   logic                      test_on, err_ev, wr, rd;
   logic [`SLBC_IRQ_W-1:0]    ev;

   assign test_on = en_pin | ctrl_q[`SLBC_CTRL_EN_BIT];
   assign err_ev  = (st_q == SLBC_CHECK) && rx_lock_i && sym_valid_i
                    && is_error(sym_payload_i);
   assign wr      = wb_cyc_i && wb_stb_i && !ack_q && wb_we_i;
   assign rd      = wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i;

   always_comb begin
      st_d      = st_q;
      res_d     = res_q;
      any_err_d = any_err_q;
      err_d     = err_q;
      pulse_d   = pulse_q;
      ev        = '0;
      case (st_q)
         SLBC_IDLE, SLBC_DONE: begin
            if (test_on) begin
               st_d      = SLBC_REQ;
               any_err_d = 1'b0;
               err_d     = `SLBC_ERR_RST;
               res_d     = 1'b0;
            end
         end
         SLBC_REQ: begin
            if (!test_on) begin
               st_d = SLBC_DONE;
               ev[`SLBC_IRQ_DONE_BIT] = 1'b1;
            end else if (remote_in_test_i && rx_lock_i) begin
               st_d  = SLBC_CHECK;
               res_d = 1'b1;
               ev[`SLBC_IRQ_START_BIT] = 1'b1;
            end
         end
         SLBC_CHECK: begin
            if (!test_on) begin
               st_d    = SLBC_DONE;
               pulse_d = 1'b0;
               res_d   = !any_err_q && !err_ev;
               ev[`SLBC_IRQ_DONE_BIT] = 1'b1;
            end else begin
               if (err_ev) begin
                  any_err_d = 1'b1;
                  pulse_d   = 1'b1;
                  res_d     = 1'b0;
                  ev[`SLBC_IRQ_ERR_BIT] = 1'b1;
                  if (err_q != 8'hff) begin
                     err_d = err_q + 8'h01;
                  end
               end else if (pulse_q && half_pclk_en_i) begin
                  pulse_d = 1'b0;
                  res_d   = 1'b1;
               end
            end
         end
         default: st_d = SLBC_IDLE;
      endcase
   end

   always_comb begin
      ctrl_d  = ctrl_q;
      imask_d = imask_q;
      ist_d   = ist_q;
      rdat_d  = 32'h0;
      ack_d   = wb_cyc_i && wb_stb_i && !ack_q;
      if (wr && wb_sel_i[0]) begin
         case (wb_adr_i)
            `SLBC_ADDR_CTRL:     ctrl_d  = wb_dat_i[1:0];
            `SLBC_ADDR_IRQ_MASK: imask_d = wb_dat_i[`SLBC_IRQ_W-1:0];
            default: ;
         endcase
      end
      if (rd) begin
         case (wb_adr_i)
            `SLBC_ADDR_CTRL:     rdat_d = {30'h0, ctrl_q};
            `SLBC_ADDR_STATUS:   rdat_d = {27'h0, clk_pin | ctrl_q[`SLBC_CTRL_OSC_BIT], res_q,
                                           rx_lock_i, st_q == SLBC_CHECK, st_q != SLBC_IDLE};
            `SLBC_ADDR_IRQ_STAT: begin
               rdat_d = {29'h0, ist_q};
               ist_d  = '0;
            end
            `SLBC_ADDR_IRQ_MASK: rdat_d = {29'h0, imask_q};
            `SLBC_ADDR_FWD_ERR:  rdat_d = {24'h0, err_q};
            default:             rdat_d = 32'h0;
         endcase
      end
      // set wins over the read clear
      ist_d = ist_d | ev;
   end

   always_comb begin
      req_d  = (st_q == SLBC_REQ) || (st_q == SLBC_CHECK);
      osc_d  = !pclk_present_i && (clk_pin || ctrl_q[`SLBC_CTRL_OSC_BIT]);
      lock_d = rx_lock_i;
      norm_d = !test_on;
      irq_d  = |(ist_d & imask_q);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q      <= SLBC_IDLE;
         ctrl_q    <= `SLBC_CTRL_RST;
         imask_q   <= `SLBC_MASK_RST;
         ist_q     <= '0;
         err_q     <= `SLBC_ERR_RST;
         res_q     <= 1'b1;
         any_err_q <= 1'b0;
         pulse_q   <= 1'b0;
         ack_q     <= 1'b0;
         rdat_q    <= 32'h0;
         req_q     <= 1'b0;
         osc_q     <= 1'b0;
         lock_q    <= 1'b0;
         norm_q    <= 1'b1;
         irq_q     <= 1'b0;
      end else begin
         st_q      <= st_d;
         ctrl_q    <= ctrl_d;
         imask_q   <= imask_d;
         ist_q     <= ist_d;
         err_q     <= err_d;
         res_q     <= res_d;
         any_err_q <= any_err_d;
         pulse_q   <= pulse_d;
         ack_q     <= ack_d;
         rdat_q    <= rdat_d;
         req_q     <= req_d;
         osc_q     <= osc_d;
         lock_q    <= lock_d;
         norm_q    <= norm_d;
         irq_q     <= irq_d;
      end
   end

   assign wb_dat_o                  = rdat_q;
   assign wb_ack_o                  = ack_q;
   assign result_pin_o              = res_q;
   assign use_internal_oscillator_o = osc_q;
   assign bc_test_request_o         = req_q;
   assign lock_o                    = lock_q;
   assign normal_mode_o             = norm_q;
   assign irq_o                     = irq_q;

   // assertions
   sequence s_err_hit;
      st_q == SLBC_CHECK && test_on && err_ev;
   endsequence

   property p_start_req;
      @(posedge clk_i) disable iff (rst_i)
      (st_q == SLBC_IDLE && test_on) |=> ##1 bc_test_request_o;
   endproperty
   a_start_req: assert property (p_start_req) else $error("test request not raised");

   property p_entry;
      @(posedge clk_i) disable iff (rst_i)
      (st_q == SLBC_IDLE && test_on) |=> st_q == SLBC_REQ;
   endproperty
   a_entry: assert property (p_entry) else $error("self test not entered");

   property p_check_high;
      @(posedge clk_i) disable iff (rst_i)
      (st_q == SLBC_REQ && test_on && remote_in_test_i && rx_lock_i) |=> (result_pin_o && st_q == SLBC_CHECK);
   endproperty
   a_check_high: assert property (p_check_high) else $error("result not high at check start");

   property p_err_low;
      @(posedge clk_i) disable iff (rst_i)
      s_err_hit |=> !result_pin_o;
   endproperty
   a_err_low: assert property (p_err_low) else $error("error pulse missing");

   property p_err_count;
      @(posedge clk_i) disable iff (rst_i)
      (s_err_hit and err_q != 8'hff) |=> err_q == $past(err_q) + 8'h01;
   endproperty
   a_err_count: assert property (p_err_count) else $error("error count not advanced");

   property p_final;
      @(posedge clk_i) disable iff (rst_i)
      (st_q == SLBC_CHECK && !test_on) |=> (st_q == SLBC_DONE && result_pin_o == !$past(any_err_q || err_ev));
   endproperty
   a_final: assert property (p_final) else $error("final result wrong");

   property p_hold;
      @(posedge clk_i) disable iff (rst_i)
      (st_q == SLBC_DONE && !test_on) |=> $stable(result_pin_o);
   endproperty
   a_hold: assert property (p_hold) else $error("final result not held");

   property p_lock;
      @(posedge clk_i) disable iff (rst_i)
      st_q == SLBC_CHECK |=> lock_o == $past(rx_lock_i);
   endproperty
   a_lock: assert property (p_lock) else $error("lock not mirrored");

   property p_normal;
      @(posedge clk_i) disable iff (rst_i)
      !test_on |=> normal_mode_o;
   endproperty
   a_normal: assert property (p_normal) else $error("normal mode not restored");

   property p_osc;
      @(posedge clk_i) disable iff (rst_i)
      (!pclk_present_i && ctrl_q[`SLBC_CTRL_OSC_BIT]) |=> use_internal_oscillator_o;
   endproperty
   a_osc: assert property (p_osc) else $error("oscillator not selected");

   property p_stop;
      @(posedge clk_i) disable iff (rst_i)
      (st_q == SLBC_DONE && !test_on) |=> (st_q == SLBC_DONE && $stable(err_q));
   endproperty
   a_stop: assert property (p_stop) else $error("checking after stop");

   // a pulse must end at the next half period strobe, or the pulses cannot be counted
   property p_pulse_end;
      @(posedge clk_i) disable iff (rst_i)
      (st_q == SLBC_CHECK && test_on && pulse_q && !err_ev && half_pclk_en_i) |=> result_pin_o;
   endproperty
   a_pulse_end: assert property (p_pulse_end) else $error("error pulse not ended");
endmodule // slbc_checker
`default_nettype wire

// ### sim/slbc_remote_model.sv
`timescale 1ns/1ns
`default_nettype none
module slbc_remote_model (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // back channel and bench control
   input  wire logic        bc_req_i,
   input  wire logic        slow_i,
   input  wire logic        err_req_i,
   input  wire logic [34:0] err_pat_i,
   input  wire logic [3:0]  straps_i,
   input  wire logic        bc_link_i,
   input  wire logic        crc_bad_i,
   // forward channel
   output logic             in_test_o,
   output logic             sym_valid_o,
   output logic [34:0]      payload_o,
   output logic             half_en_o,
   output logic [7:0]       crc_err_o
);
   logic [3:0] wake_q;
   logic [1:0] ph_q;
   logic       err_q;
   always_ff @(posedge clk_i) begin
      if (rst_i || !bc_req_i) begin
         wake_q    <= 4'h0;
         in_test_o <= 1'b0;
      end else if (straps_i != 4'h1) begin
         wake_q <= 4'h0;
      end else if (wake_q < (slow_i ? 4'hc : 4'h2)) begin
         wake_q <= wake_q + 4'h1;
      end else begin
         in_test_o <= 1'b1;
      end
      // count survives the run, cleared only by reset or when a new run starts
      if (rst_i || (bc_req_i && !in_test_o)) crc_err_o <= 8'h00;
      else if (in_test_o && bc_link_i && crc_bad_i && crc_err_o != 8'hff) crc_err_o <= crc_err_o + 8'h01;
      ph_q        <= (rst_i || !in_test_o) ? 2'h0 : ph_q + 2'h1;
      sym_valid_o <= in_test_o && ph_q == 2'h0;
      half_en_o   <= in_test_o && ph_q == 2'h2;
      err_q       <= err_req_i | (err_q & !(in_test_o && ph_q == 2'h0));
      // idle payload toggles so a design that ignores valid sees garbage
      if (rst_i) payload_o <= 35'h0;
      else if (in_test_o && ph_q == 2'h0) payload_o <= err_q ? err_pat_i : 35'h0;
      else payload_o <= ~payload_o;
   end
endmodule // slbc_remote_model
`default_nettype wire

// ### sim/serial_link_bist_checker_test.sv
`timescale 1ns/1ns
`default_nettype none
module serial_link_bist_checker_test;
   logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic        wb_ack_o, result_pin_o, use_internal_oscillator_o, bc_test_request_o, lock_o, normal_mode_o, irq_o;
   logic        self_test_enable_pin_i = 1'b0, self_test_clock_select_pin_i = 1'b0, pclk_present_i = 1'b1;
   logic        rx_lock_i = 1'b0, remote_in_test_i, sym_valid_i, half_pclk_en_i, slow = 1'b0, err_req = 1'b0, res_q;
   logic [34:0] sym_payload_i, err_pat = 35'h0;
   logic [31:0] seed = 32'h0000_4420;
   logic [7:0]  crc_cnt;
   logic [3:0]  straps = 4'h1;
   logic        bc_link = 1'b0, crc_bad = 1'b0;
   int          err_total = 0, tests_run = 0, pulses = 0, cyc_n = 0, n;

   slbc_checker uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
      .wb_ack_o, .self_test_enable_pin_i, .self_test_clock_select_pin_i, .pclk_present_i, .result_pin_o,
      .use_internal_oscillator_o, .rx_lock_i, .remote_in_test_i, .sym_valid_i, .sym_payload_i, .half_pclk_en_i,
      .bc_test_request_o, .lock_o, .normal_mode_o, .irq_o);
   slbc_remote_model remote (.clk_i, .rst_i, .bc_req_i(bc_test_request_o), .slow_i(slow), .err_req_i(err_req),
      .err_pat_i(err_pat), .in_test_o(remote_in_test_i), .sym_valid_o(sym_valid_i), .payload_o(sym_payload_i),
      .half_en_o(half_pclk_en_i), .straps_i(straps), .bc_link_i(bc_link), .crc_bad_i(crc_bad),
      .crc_err_o(crc_cnt));

   initial begin
      forever #2 clk_i = ~clk_i;
   end
   // falling edges of the result pin are the countable error pulses
   always @(posedge clk_i) begin
      res_q <= result_pin_o;
      if (res_q === 1'b1 && result_pin_o === 1'b0) pulses++;
      cyc_n++;
      if (cyc_n == 20000) begin
         err_total++;
         summarize();
      end
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int k;
      k = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= 4'hf;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1);
      chk(32'(k < 50), 32'h1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wait_req(input logic v);
      for (int k = 0; k < 60 && bc_test_request_o !== v; k++) @(posedge clk_i);
   endtask
   task automatic run_test(input logic by_reg, input int nerr, input logic slw);
      int base;
      slow <= slw;
      if (by_reg) wb(1'b1, 8'h00, 32'h1);
      else self_test_enable_pin_i <= 1'b1;
      wait_req(1'b1);
      chk(32'(bc_test_request_o), 32'h1);
      for (int k = 0; k < 60 && remote_in_test_i !== 1'b1; k++) @(posedge clk_i);
      repeat (3) @(posedge clk_i);
      chk(32'(crc_cnt), 32'h0);
      wb(1'b0, 8'h04, 32'h0);
      chk(rd & 32'h6, 32'h6);
      chk(32'(result_pin_o), 32'h1);
      chk(32'(normal_mode_o), 32'h0);
      wb(1'b0, 8'h94, 32'h0);
      chk(rd, 32'h0);
      base = pulses;
      for (int e = 0; e < nerr; e++) begin
         err_pat <= {3'h0, xs()};
         err_req <= 1'b1;
         @(posedge clk_i);
         err_req <= 1'b0;
         repeat (9) @(posedge clk_i);
      end
      chk(32'(pulses - base), 32'(nerr));
      chk(32'(lock_o), 32'(rx_lock_i));
      wb(1'b0, 8'h94, 32'h0);
      chk(rd, 32'(nerr));
      // a bad frame before back-channel link detect must not be counted
      bc_link <= 1'b0;
      crc_bad <= 1'b1;
      @(posedge clk_i);
      crc_bad <= 1'b0;
      bc_link <= 1'b1;
      @(posedge clk_i);
      chk(32'(crc_cnt), 32'h0);
      for (int e = 0; e < nerr; e++) begin
         crc_bad <= 1'b1;
         @(posedge clk_i);
         crc_bad <= 1'b0;
         @(posedge clk_i);
      end
      if (by_reg) wb(1'b1, 8'h00, 32'h0);
      else self_test_enable_pin_i <= 1'b0;
      wait_req(1'b0);
      repeat (20) @(posedge clk_i);
      chk(32'(result_pin_o), 32'(nerr == 0));
      chk(32'(normal_mode_o), 32'h1);
      chk(32'(crc_cnt), 32'(nerr));
   endtask
   task automatic summarize();
      $display("mismatches %0d of %0d checks", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge clk_i);
      rst_i     <= 1'b0;
      rx_lock_i <= 1'b1;
      @(posedge clk_i);
      chk(32'(result_pin_o), 32'h1);
      wb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      wb(1'b1, 8'h94, 32'hff);
      wb(1'b0, 8'h94, 32'h0);
      chk(rd, 32'h0);
      wb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      for (int i = 0; i < 4; i++) begin
         pclk_present_i               <= i[0];
         self_test_clock_select_pin_i <= i[1];
         repeat (8) @(posedge clk_i);
         chk(32'(use_internal_oscillator_o), 32'(!i[0] && i[1]));
      end
      // oscillator chosen by the control register alone, pin released
      pclk_present_i               <= 1'b0;
      self_test_clock_select_pin_i <= 1'b0;
      wb(1'b1, 8'h00, 32'h2);
      repeat (8) @(posedge clk_i);
      chk(32'(use_internal_oscillator_o), 32'h1);
      wb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h2);
      wb(1'b1, 8'h00, 32'h0);
      pclk_present_i <= 1'b1;
      run_test(1'b0, 0, 1'b0);
      chk(32'(irq_o), 32'h0);
      wb(1'b1, 8'h0c, 32'h7);
      n = 1 + int'(xs() % 4);
      run_test(1'b1, n, 1'b1);
      chk(32'(irq_o), 32'h1);
      wb(1'b0, 8'h08, 32'h0);
      chk(rd & 32'h7, 32'h7);
      repeat (2) @(posedge clk_i);
      chk(32'(irq_o), 32'h0);
      chk(32'(result_pin_o), 32'h0);
      // a reset after the failed run discards its result and the count
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk(32'(result_pin_o), 32'h1);
      wb(1'b0, 8'h94, 32'h0);
      chk(rd, 32'h0);
      run_test(1'b0, 0, 1'b0);
      summarize();
   end
endmodule // serial_link_bist_checker_test
`default_nettype wire
